// >>> hw/ctp_timer.sv
// Compact 16-bit timer with compare-match, timer/counter and PWM modes.
// Assumes an APB master on the system clock; pins are asynchronous.
//
// Function
// - 16-bit up-counter; A compares 16 bits, P compares top 8 bits.
// - Software cannot load counter; on-bit rising edge zeroes it.
// - Counter clears on overflow or selected match; events flag.
// - Pause bit holds counter value; clearing it resumes counting.
// - Clock select picks divided system clocks, time base or pin edge.
// - On bit runs counter; clearing it stops and keeps the value.
// - Compare mode: on-bit rising edge resets pin to initial level.
// - Mode field: compare, undefined, PWM, timer; timer leaves pin unused.
// - Compare mode on A match: keep, low, high or toggle.
// - PWM mode function: force inactive, force active, waveform.
// - Output control bit: initial level or PWM active level.
// - Polarity bit inverts the pin in compare and PWM modes.
// - Swap bit chooses which comparator sets PWM period and duty.
// - Clear select picks A match or P match/overflow; PWM ignores it.
// - Counter pair read-only, compare A pair read/write, reset zero.
// - Low bytes go through a buffer committed by high-byte access.
// - P value zero gives 65536-clock period, else multiples of 256.
// - Clear on A: no P flag; zero A overflows without A flag.
// - PWM duty at or above period gives full active level.
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps

module ctp_timer
    import ctp_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic external_clock_pin,
    input wire logic time_base_clock,
    output logic timer_output_pin,
    output logic timer_output_oe_n,
    output logic compare_a_flag,
    output logic compare_p_flag
);

    ctp_ctl0_type ctl0_reg;
    ctp_ctl1_type ctl1_reg;
    logic [15:0] count_reg;
    logic [15:0] compare_a_value;
    logic [7:0] compare_p_value;
    logic [7:0] low_buffer_reg;
    logic [5:0] prescale_reg;
    logic [1:0] pin_sync_reg;
    logic pin_last_reg;
    logic [1:0] tbc_sync_reg;
    logic tbc_last_reg;
    logic on_last_reg;
    logic compare_level_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;

    logic setup_phase;
    logic access_done;
    logic wr_en;
    logic on_rise;
    logic tick;
    logic running;
    logic [15:0] count_next;
    logic a_hit;
    logic p_hit;
    logic is_pwm;
    logic clear_now;
    logic a_event;
    logic p_event;
    logic [16:0] duty_value;
    logic pwm_active;
    logic level_next;
    logic drive_pin;

    // Picks the timer clock enable for one cycle of the system clock
    function automatic logic clock_tick(input ctp_clk_sel_type sel,
                                        input logic [5:0] pre,
                                        input logic tbc_edge,
                                        input logic pin_rise,
                                        input logic pin_fall);
        logic t;
        t = 1'b0;
        case (sel)
            CTP_CLK_SYS_DIV4: t = (pre[1:0] == CTP_DIV4_TAP[1:0]);
            CTP_CLK_SYS: t = 1'b1;
            CTP_CLK_HIGH_DIV16: t = (pre[3:0] == CTP_DIV16_TAP[3:0]);
            CTP_CLK_HIGH_DIV64: t = (pre == CTP_DIV64_TAP);
            CTP_CLK_TIME_BASE: t = tbc_edge;
            CTP_CLK_HIGH_DIV8: t = (pre[2:0] == CTP_DIV8_TAP[2:0]);
            CTP_CLK_PIN_RISE: t = pin_rise;
            default: t = pin_fall;
        endcase
        return t;
    endfunction

    assign setup_phase = psel && !penable;
    assign access_done = psel && penable && pready_reg;
    assign wr_en = access_done && pwrite && !pslverr_reg;

    // Free-running prescaler; one pulse per divided period
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prescale_reg <= 6'h00;
        end else begin
            prescale_reg <= prescale_reg + 6'h01;
        end
    end

    // Both asynchronous clock inputs pass two flops before edge detection
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pin_sync_reg <= 2'h0;
            pin_last_reg <= 1'b0;
            tbc_sync_reg <= 2'h0;
            tbc_last_reg <= 1'b0;
        end else begin
            pin_sync_reg <= {pin_sync_reg[0], external_clock_pin};
            pin_last_reg <= pin_sync_reg[1];
            tbc_sync_reg <= {tbc_sync_reg[0], time_base_clock};
            tbc_last_reg <= tbc_sync_reg[1];
        end
    end

    assign tick = clock_tick(ctl0_reg.clock_source_select, prescale_reg,
                             tbc_sync_reg[1] && !tbc_last_reg,
                             pin_sync_reg[1] && !pin_last_reg,
                             !pin_sync_reg[1] && pin_last_reg);

    assign on_rise = ctl0_reg.timer_on && !on_last_reg;
    // Off or paused: no ticks, value kept
    assign running = ctl0_reg.timer_on && !ctl0_reg.counter_pause
                     && !on_rise && tick;
    assign count_next = count_reg + 16'h0001;

    // Matches are judged on the value the counter is about to take
    assign a_hit = (count_next == compare_a_value);
    assign p_hit = (count_next[15:8] == compare_p_value)
                   && (count_next[7:0] == 8'h00);
    assign is_pwm = (ctl1_reg.operating_mode_select == CTP_MODE_PWM);

    always_comb begin
        clear_now = 1'b0;
        if (is_pwm) begin
            clear_now = ctl1_reg.period_duty_swap ? a_hit : p_hit;
        end else if (ctl1_reg.counter_clear_select) begin
            clear_now = a_hit;
        end else begin
            clear_now = p_hit;
        end
    end

    // Zero compare A means a wrap, not a match
    assign a_event = running && a_hit
                     && (compare_a_value != 16'h0000);
    assign p_event = running && p_hit && (is_pwm
                     || !ctl1_reg.counter_clear_select);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            on_last_reg <= 1'b0;
        end else begin
            on_last_reg <= ctl0_reg.timer_on;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            count_reg <= 16'h0000;
        end else if (on_rise) begin
            count_reg <= 16'h0000;
        end else if (running) begin
            if (clear_now) begin
                count_reg <= 16'h0000;
            end else begin
                count_reg <= count_next;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            compare_a_flag <= 1'b0;
            compare_p_flag <= 1'b0;
        end else begin
            compare_a_flag <= a_event;
            compare_p_flag <= p_event;
        end
    end

    // Compare-mode pin state before polarity
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            compare_level_reg <= 1'b0;
        end else if (ctl1_reg.operating_mode_select == CTP_MODE_COMPARE) begin
            if (on_rise) begin
                compare_level_reg <= ctl1_reg.output_initial_level;
            end else if (a_event) begin
                case (ctl1_reg.output_function_select)
                    CTP_IO_LOW: compare_level_reg <= 1'b0;
                    CTP_IO_HIGH: compare_level_reg <= 1'b1;
                    CTP_IO_TOGGLE: begin
                        compare_level_reg <= !compare_level_reg;
                    end
                    default: compare_level_reg <= compare_level_reg;
                endcase
            end
        end
    end

    // Duty as a 17-bit figure so a zero P value stands for 65536
    always_comb begin
        if (!ctl1_reg.period_duty_swap) begin
            duty_value = {1'b0, compare_a_value};
        end else if (compare_p_value == 8'h00) begin
            duty_value = 17'h10000;
        end else begin
            duty_value = {1'b0, compare_p_value, 8'h00};
        end
    end

    // Counter never passes the period, so duty at or above it stays active
    assign pwm_active = ({1'b0, count_reg} < duty_value);

    always_comb begin
        level_next = 1'b0;
        drive_pin = 1'b0;
        case (ctl1_reg.operating_mode_select)
            CTP_MODE_COMPARE: begin
                level_next = compare_level_reg;
                drive_pin = 1'b1;
            end
            CTP_MODE_PWM: begin
                drive_pin = 1'b1;
                case (ctl1_reg.output_function_select)
                    CTP_IO_LOW: level_next = 1'b1;
                    CTP_IO_HIGH: level_next = pwm_active;
                    default: level_next = 1'b0;
                endcase
                // Output control bit gives the active level
                // Active low turns the active state into a low pin
                level_next = (level_next == ctl1_reg.output_initial_level)
                             ? 1'b1 : 1'b0;
            end
            default: begin
                level_next = 1'b0;
                drive_pin = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            timer_output_pin <= 1'b0;
            timer_output_oe_n <= 1'b1;
        end else begin
            timer_output_pin <= drive_pin
                && (level_next ^ ctl1_reg.output_polarity_invert);
            // Pin released while the timer is off, for shared use
            timer_output_oe_n <= !(drive_pin && ctl0_reg.timer_on);
        end
    end

    // Register writes; counter has no write path
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctl0_reg <= ctp_ctl0_type'(CTP_CTL0_RESET);
            ctl1_reg <= ctp_ctl1_type'(CTP_CTL1_RESET);
            compare_a_value <= CTP_CMPA_RESET;
            compare_p_value <= CTP_PER_RESET;
        end else if (wr_en) begin
            if (paddr == CTP_ADDR_CTL0) begin
                ctl0_reg <= ctp_ctl0_type'(pwdata[7:0] & CTP_CTL0_MASK);
            end else if (paddr == CTP_ADDR_CTL1) begin
                ctl1_reg <= ctp_ctl1_type'(pwdata[7:0]);
            end else if (paddr == CTP_ADDR_CMPA_HI) begin
                compare_a_value <= {pwdata[7:0], low_buffer_reg};
            end else if (paddr == CTP_ADDR_PER) begin
                compare_p_value <= pwdata[7:0];
            end
        end
    end

    // Shared low-byte buffer; high-byte reads latch at the setup edge so
    // the returned high byte and buffered low byte are one snapshot
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            low_buffer_reg <= 8'h00;
        end else if (wr_en && paddr == CTP_ADDR_CMPA_LO) begin
            low_buffer_reg <= pwdata[7:0];
        end else if (setup_phase && !pwrite) begin
            if (paddr == CTP_ADDR_CNT_HI) begin
                low_buffer_reg <= count_reg[7:0];
            end else if (paddr == CTP_ADDR_CMPA_HI) begin
                low_buffer_reg <= compare_a_value[7:0];
            end
        end
    end

    // APB answer: no wait states, read data captured in the setup cycle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prdata_reg <= 32'h00000000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else if (setup_phase) begin
            pready_reg <= 1'b1;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
            if (paddr == CTP_ADDR_CTL0) begin
                prdata_reg[7:0] <= ctl0_reg;
            end else if (paddr == CTP_ADDR_CTL1) begin
                prdata_reg[7:0] <= ctl1_reg;
            end else if (paddr == CTP_ADDR_CNT_LO
                         || paddr == CTP_ADDR_CMPA_LO) begin
                prdata_reg[7:0] <= low_buffer_reg;
            end else if (paddr == CTP_ADDR_CNT_HI) begin
                prdata_reg[7:0] <= count_reg[15:8];
            end else if (paddr == CTP_ADDR_CMPA_HI) begin
                prdata_reg[7:0] <= compare_a_value[15:8];
            end else if (paddr == CTP_ADDR_PER) begin
                prdata_reg[7:0] <= compare_p_value;
            end else begin
                pslverr_reg <= 1'b1;
            end
        end else begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    // Error flop only rises together with pready, so it stands alone
    assign pslverr = pslverr_reg;

endmodule // ctp_timer

// >>> hw/ctp_pkg.sv
// Package for the compact timer with PWM: register map, fields, encodings.
// Assumes one 100 MHz system clock; the high clock equals the system clock.
package ctp_pkg;

    localparam logic [7:0] CTP_ADDR_CTL0 = 8'h00;
    localparam logic [7:0] CTP_ADDR_CTL1 = 8'h04;
    localparam logic [7:0] CTP_ADDR_CNT_LO = 8'h08;
    localparam logic [7:0] CTP_ADDR_CNT_HI = 8'h0C;
    localparam logic [7:0] CTP_ADDR_CMPA_LO = 8'h10;
    localparam logic [7:0] CTP_ADDR_CMPA_HI = 8'h14;
    localparam logic [7:0] CTP_ADDR_PER = 8'h18;

    localparam logic [7:0] CTP_CTL0_RESET = 8'h00;
    localparam logic [7:0] CTP_CTL1_RESET = 8'h00;
    localparam logic [15:0] CTP_CMPA_RESET = 16'h0000;
    localparam logic [7:0] CTP_PER_RESET = 8'h00;
    localparam logic [7:0] CTP_CTL0_MASK = 8'hF8;

    // Prescaler taps: divide ratios minus one on a free-running counter
    localparam logic [5:0] CTP_DIV4_TAP = 6'h03;
    localparam logic [5:0] CTP_DIV8_TAP = 6'h07;
    localparam logic [5:0] CTP_DIV16_TAP = 6'h0F;
    localparam logic [5:0] CTP_DIV64_TAP = 6'h3F;

    typedef enum logic [2:0] {
        CTP_CLK_SYS_DIV4 = 3'h0,
        CTP_CLK_SYS = 3'h1,
        CTP_CLK_HIGH_DIV16 = 3'h2,
        CTP_CLK_HIGH_DIV64 = 3'h3,
        CTP_CLK_TIME_BASE = 3'h4,
        CTP_CLK_HIGH_DIV8 = 3'h5,
        CTP_CLK_PIN_RISE = 3'h6,
        CTP_CLK_PIN_FALL = 3'h7
    } ctp_clk_sel_type;

    typedef enum logic [1:0] {
        CTP_MODE_COMPARE = 2'h0,
        CTP_MODE_UNDEF = 2'h1,
        CTP_MODE_PWM = 2'h2,
        CTP_MODE_TIMER = 2'h3
    } ctp_mode_type;

    typedef enum logic [1:0] {
        CTP_IO_NONE = 2'h0,
        CTP_IO_LOW = 2'h1,
        CTP_IO_HIGH = 2'h2,
        CTP_IO_TOGGLE = 2'h3
    } ctp_io_type;

    // Control register 0: pause bit 7, clock select 6..4, on bit 3
    typedef struct packed {
        logic counter_pause;
        ctp_clk_sel_type clock_source_select;
        logic timer_on;
        logic [2:0] unused;
    } ctp_ctl0_type;

    // Control register 1
    typedef struct packed {
        ctp_mode_type operating_mode_select;
        ctp_io_type output_function_select;
        logic output_initial_level;
        logic output_polarity_invert;
        logic period_duty_swap;
        logic counter_clear_select;
    } ctp_ctl1_type;

endpackage

// >>> dv/ctp_timer_monitor.sv
// Checker for the compact timer, watching the top-level ports only.
// Assumes APB setup and access phases in order; shadows software writes.
`timescale 1ns/1ps
module ctp_timer_monitor
    import ctp_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic timer_output_pin,
    input wire logic timer_output_oe_n,
    input wire logic compare_a_flag,
    input wire logic compare_p_flag
);
    ctp_ctl0_type c0_reg;
    ctp_ctl1_type c1_reg;
    logic [7:0] ah_reg;
    logic wr_en;
    logic drive;
    logic level;
    assign wr_en = psel && penable && pready && pwrite;
    assign drive = c0_reg.timer_on
        && (c1_reg.operating_mode_select == CTP_MODE_COMPARE
        || c1_reg.operating_mode_select == CTP_MODE_PWM);
    assign level = c1_reg.output_initial_level ^ c1_reg.output_polarity_invert;
    // Shadow only what software wrote; the counter itself stays unseen
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            c0_reg <= ctp_ctl0_type'(CTP_CTL0_RESET);
            c1_reg <= ctp_ctl1_type'(CTP_CTL1_RESET);
            ah_reg <= 8'h00;
        end else if (wr_en && paddr == CTP_ADDR_CTL0) begin
            c0_reg <= ctp_ctl0_type'(pwdata[7:0] & CTP_CTL0_MASK);
        end else if (wr_en && paddr == CTP_ADDR_CTL1) begin
            c1_reg <= ctp_ctl1_type'(pwdata[7:0]);
        end else if (wr_en && paddr == CTP_ADDR_CMPA_HI) begin
            ah_reg <= pwdata[7:0];
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_on_rise;
        wr_en && paddr == CTP_ADDR_CTL0 && pwdata[3] && !c0_reg.timer_on
            && c1_reg.operating_mode_select == CTP_MODE_COMPARE;
    endsequence
    sequence s_forced;
        c0_reg.timer_on && c1_reg.operating_mode_select == CTP_MODE_PWM
            && (c1_reg.output_function_select == CTP_IO_NONE
            || c1_reg.output_function_select == CTP_IO_LOW);
    endsequence
    sequence s_clear_on_a;
        c1_reg.counter_clear_select
            && c1_reg.operating_mode_select != CTP_MODE_PWM;
    endsequence
    AST_APB_ANSWER: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    AST_UNMAPPED: assert property (
        pready |-> pslverr == !(paddr[1:0] == 2'h0 && paddr <= CTP_ADDR_PER))
        else $error("error flag wrong for address");
    AST_CTL0_READ: assert property (
        pready && !pwrite && paddr == CTP_ADDR_CTL0
            |-> prdata == {24'h000000, c0_reg})
        else $error("control 0 read back wrong");
    AST_CMPA_HI: assert property (
        pready && !pwrite && paddr == CTP_ADDR_CMPA_HI
            |-> prdata == {24'h000000, ah_reg})
        else $error("compare high byte read back wrong");
    AST_OE_ON: assert property (drive |=> !timer_output_oe_n)
        else $error("pin not driven");
    AST_OE_OFF: assert property (!drive |=> timer_output_oe_n)
        else $error("pin driven while unused");
    AST_NO_P_FLAG: assert property (
        s_clear_on_a [*3] |-> !compare_p_flag)
        else $error("P flag with clear on A");
    AST_A_PULSE: assert property (
        compare_a_flag && c0_reg.clock_source_select != CTP_CLK_SYS
            |=> !compare_a_flag)
        else $error("A flag longer than one cycle");
    AST_PIN_INIT: assert property (
        s_on_rise |-> ##[1:3] timer_output_pin == level)
        else $error("pin not at initial level");
    AST_FORCED: assert property (
        s_forced [*3] |-> timer_output_pin == ((c1_reg.output_initial_level
            ~^ (c1_reg.output_function_select == CTP_IO_LOW))
            ^ c1_reg.output_polarity_invert))
        else $error("forced level wrong");
endmodule // ctp_timer_monitor

bind ctp_timer ctp_timer_monitor u_ctp_timer_monitor (
    .clock(clock), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .timer_output_pin(timer_output_pin),
    .timer_output_oe_n(timer_output_oe_n),
    .compare_a_flag(compare_a_flag), .compare_p_flag(compare_p_flag)
);

// >>> dv/ctp_pin_model.sv
// Far-side model: external clock pin source and a time-base clock.
// Assumes the bench raises ext_run only while it wants pin edges.
`timescale 1ns/1ps
module ctp_pin_model #(
    parameter int EXT_HALF = 8,
    parameter int TBASE_HALF = 10
) (
    input wire logic clock,
    input wire logic ext_run,
    output logic external_clock_pin,
    output logic time_base_clock
);
    int ext_cnt = 0;
    initial external_clock_pin = 1'b0;
    // Pin edges only in a burst; the pin rests low between bursts
    always @(posedge clock) begin
        ext_cnt <= ext_run ? (ext_cnt + 1) % EXT_HALF : 0;
        if (!ext_run) begin
            external_clock_pin <= 1'b0;
        end else if (ext_cnt == EXT_HALF - 1) begin
            external_clock_pin <= ~external_clock_pin;
        end
    end
    // Time base runs free, offset so it never lines up with the clock
    initial begin
        time_base_clock = 1'b0;
        #3;
        forever #(TBASE_HALF * 10) time_base_clock = ~time_base_clock;
    end
endmodule // ctp_pin_model

// >>> dv/tb_ctp_timer.sv
// Bench for the compact timer: APB tasks and one task per scenario.
// Assumes the pin model feeds the clock pins and the monitor is bound.
`timescale 1ns/1ps
module tb_ctp_timer
    import ctp_pkg::*;
;
    localparam int EXT_HALF = 8;
    localparam int TBASE_HALF = 10;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ext_run = 1'b0;
    logic ext_pin;
    logic tbase;
    logic pin;
    logic oe_n;
    logic flag_a;
    logic flag_p;
    logic last_err;
    int err_total = 0;
    int n_checks = 0;

    always #5 clock = ~clock;

    ctp_timer u_ctp_timer (
        .clock(clock), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_clock_pin(ext_pin), .time_base_clock(tbase),
        .timer_output_pin(pin), .timer_output_oe_n(oe_n),
        .compare_a_flag(flag_a), .compare_p_flag(flag_p)
    );
    ctp_pin_model #(.EXT_HALF(EXT_HALF), .TBASE_HALF(TBASE_HALF))
        u_ctp_pin_model (.clock(clock), .ext_run(ext_run),
        .external_clock_pin(ext_pin), .time_base_clock(tbase));

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            err_total++;
            $display("Error %0t: got %h want %h", $time, s, e);
        end
    endtask
    task automatic near(input int s, input int e);
        chk({31'h0, (s >= e - 3) && (s <= e + 3)}, 32'h1);
    endtask
    // Request held until pready is seen high at an edge
    task automatic apb(input logic [7:0] a, input logic w,
            input logic [7:0] d, output logic [31:0] r);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= {24'h000000, d};
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        // Only the watchdog ends a wait for the answer
        while (pready !== 1'b1) begin
            @(posedge clock);
        end
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        apb(a, 1'b1, d, r);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        apb(a, 1'b0, 8'h00, r);
    endtask
    task automatic rd_cnt(output logic [15:0] c);
        logic [31:0] h;
        logic [31:0] l;
        rd(CTP_ADDR_CNT_HI, h);
        rd(CTP_ADDR_CNT_LO, l);
        c = {h[7:0], l[7:0]};
    endtask
    task automatic set_a(input logic [15:0] a);
        wr(CTP_ADDR_CMPA_LO, a[7:0]);
        wr(CTP_ADDR_CMPA_HI, a[15:8]);
    endtask

    task automatic t_regs;
        logic [31:0] r;
        for (int i = 0; i < 7; i++) begin
            rd(8'(4 * i), r);
            chk(r, 32'h0);
        end
        wr(CTP_ADDR_CNT_HI, 8'h5A);
        rd(CTP_ADDR_CNT_HI, r);
        chk(r, 32'h0);
        rd(8'h1C, r);
        chk({31'h0, last_err}, 32'h1);
    endtask
    // Low write only fills the buffer; high read refills it
    task automatic t_pair;
        logic [31:0] h;
        logic [31:0] l;
        set_a(16'h1234);
        wr(CTP_ADDR_CMPA_LO, 8'h56);
        rd(CTP_ADDR_CMPA_HI, h);
        rd(CTP_ADDR_CMPA_LO, l);
        chk({16'h0, h[7:0], l[7:0]}, 32'h1234);
    endtask
    task automatic t_walk;
        logic [15:0] a;
        logic [15:0] b;
        int n;
        n = 0;
        wr(CTP_ADDR_CTL1, 8'h01);
        set_a(16'h0003);
        wr(CTP_ADDR_CTL0, 8'h18);
        repeat (10) @(posedge clock);
        repeat (30) begin
            @(posedge clock);
            n += int'(flag_a === 1'b1);
        end
        chk(32'(n), 32'h0000000A);
        wr(CTP_ADDR_CTL0, 8'h98);
        rd_cnt(a);
        repeat (20) @(posedge clock);
        rd_cnt(b);
        chk({16'h0, b}, {16'h0, a});
        chk({31'h0, a < 16'h0003}, 32'h1);
        wr(CTP_ADDR_CTL0, 8'h90);
        wr(CTP_ADDR_CTL0, 8'h98);
        rd_cnt(a);
        chk({16'h0, a}, 32'h0);
    endtask
    task automatic t_src;
        int dv[8] = '{4, 1, 16, 64, 2 * TBASE_HALF, 8, 2 * EXT_HALF,
            2 * EXT_HALF};
        logic [15:0] c;
        wr(CTP_ADDR_CTL0, 8'h00);
        wr(CTP_ADDR_CTL1, 8'hC0);
        ext_run <= 1'b1;
        for (int s = 0; s < 8; s++) begin
            wr(CTP_ADDR_CTL0, {1'b0, 3'(s), 4'h8});
            repeat (512) @(posedge clock);
            wr(CTP_ADDR_CTL0, {1'b1, 3'(s), 4'h8});
            rd_cnt(c);
            near(int'(c), 515 / dv[s]);
            wr(CTP_ADDR_CTL0, 8'h00);
        end
        ext_run <= 1'b0;
    endtask
    task automatic t_cmp;
        int k;
        set_a(16'h0007);
        for (int p = 0; p < 2; p++) begin
            for (int f = 1; f < 4; f++) begin
                wr(CTP_ADDR_CTL0, 8'h10);
                wr(CTP_ADDR_CTL1, {2'b00, 2'(f), 1'b1, 1'(p), 2'b01});
                wr(CTP_ADDR_CTL0, 8'h18);
                repeat (2) @(posedge clock);
                chk({31'h0, pin ^ 1'(p)}, 32'h1);
                chk({31'h0, oe_n}, 32'h0);
                k = 0;
                while (flag_a !== 1'b1 && k < 40) begin
                    @(posedge clock);
                    k++;
                end
                chk({31'h0, k < 40}, 32'h1);
                repeat (2) @(posedge clock);
                chk({31'h0, pin ^ 1'(p)}, {31'h0, f == 2});
            end
        end
    endtask
    // Window of 512 cycles covers whole periods for every entry but the swapped one, whose pin stays active
    task automatic t_pwm;
        logic [7:0] c1[7] = '{8'hA8, 8'hAC, 8'hA0, 8'hA8, 8'hAA, 8'h88, 8'h98};
        logic [7:0] pv[7] = '{8'h01, 8'h01, 8'h01, 8'h02, 8'h01, 8'h01, 8'h01};
        logic [15:0] av[7] = '{16'h0040, 16'h0040, 16'h0040, 16'h0080,
            16'h0064, 16'h0040, 16'h0040};
        int hi[7] = '{128, 384, 384, 128, 512, 0, 512};
        int np[7] = '{2, 2, 2, 1, 0, 2, 2};
        int n;
        int m;
        int x;
        for (int i = 0; i < 7; i++) begin
            wr(CTP_ADDR_CTL0, 8'h10);
            wr(CTP_ADDR_CTL1, c1[i]);
            wr(CTP_ADDR_PER, pv[i]);
            set_a(av[i]);
            wr(CTP_ADDR_CTL0, 8'h18);
            repeat (600) @(posedge clock);
            n = 0;
            m = 0;
            x = 0;
            repeat (512) begin
                @(posedge clock);
                n += int'(pin === 1'b1);
                m += int'(flag_p === 1'b1);
                x += int'(pin !== 1'b0 && pin !== 1'b1);
            end
            near(n, hi[i]);
            chk(32'(m), 32'(np[i]));
            chk(32'(x), 32'h0);
        end
    endtask

    task automatic close_out;
        if (err_total == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        t_regs();
        t_pair();
        t_walk();
        t_src();
        t_cmp();
        t_pwm();
        close_out();
    end
    // Run needs about 12400 cycles; allow a wide margin
    initial begin
        #400000;
        err_total++;
        close_out();
    end
endmodule // tb_ctp_timer
